// *** logic/suvm_pkg.sv ***
// Package with register map, field positions and timing constants of the undervoltage monitor.
package suvm_pkg;
  localparam int unsigned CLK_HZ               = 200_000_000;
  localparam logic [3:0]  ADDR_UNDERVOLT_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_CONTROL_0   = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_CONTROL_1   = 4'h2;
  localparam logic [3:0]  ADDR_EVENT_STATUS    = 4'h3;
  localparam logic [3:0]  ADDR_EVENT_MASK      = 4'h4;
  localparam logic [3:0]  ADDR_MONITOR_STATUS  = 4'h5;
  localparam int          TRIP_SEL_LSB         = 0;
  localparam int          BANDGAP_BUF_BIT      = 3;
  localparam int          DETECTOR_EN_BIT      = 4;
  localparam int          LOW_SUPPLY_BIT       = 5;
  localparam int          GLOBAL_IRQ_EN_BIT    = 0;
  localparam int          UV_IRQ_EN_BIT        = 1;
  localparam int          UV_IRQ_FLAG_BIT      = 5;
  localparam int          EVT_LOW_RISE_BIT     = 0;
  localparam int          EVT_IRQ_SET_BIT      = 1;
  localparam int          EVT_WAKE_BIT         = 2;
  localparam logic [7:0]  UNDERVOLT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  IRQ_CONTROL_0_RST    = 8'h00;
  localparam logic [7:0]  IRQ_CONTROL_1_RST    = 8'h00;
  localparam logic [7:0]  CTRL_WRITE_MASK      = 8'h1f;
  localparam logic [7:0]  IRQC0_WRITE_MASK     = 8'h7f;
  localparam logic [2:0]  EVENT_MASK_RST       = 3'h0;
  localparam int unsigned FLAG_TO_IRQ_DELAY_US = 15;
  localparam int unsigned FLAG_TO_IRQ_CYCLES   = FLAG_TO_IRQ_DELAY_US * (CLK_HZ / 1_000_000);
endpackage : suvm_pkg

// *** logic/suvm_delay.sv ***
// Delay timer that qualifies the synchronised low-supply flag before raising an interrupt request.
`timescale 1ns/100ps
`default_nettype none
module suvm_delay
  import suvm_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = FLAG_TO_IRQ_CYCLES
) (
  // Clock and reset.
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Qualified level and result.
  input  wire logic low_i,
  output var  logic expired_o
);
  localparam int CW = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

  logic [CW-1:0] count;

  // The count restarts whenever the flag drops, so a toggling flag near the trip level does not fire early.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count     <= '0;
      expired_o <= 1'b0;
    end else if (!low_i) begin
      count     <= '0;
      expired_o <= 1'b0;
    end else if (count == LAST) begin
      expired_o <= 1'b1;
    end else begin
      count     <= count + CW'(1);
    end
  end
endmodule : suvm_delay
`default_nettype wire

// *** logic/suvm_top.sv ***
// Undervoltage monitor control, status and interrupt logic behind an Avalon-MM slave.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module suvm_top
  import suvm_pkg::*;
#(
  parameter int unsigned IRQ_DELAY_CYCLES = FLAG_TO_IRQ_CYCLES
) (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Avalon-MM slave.
  input  wire logic [3:0] avs_address_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0] avs_byteenable_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic       avs_waitrequest_o,
  output var  logic [1:0] avs_response_o,
  // Analog side and power state.
  input  wire logic       comparator_i,
  input  wire logic       sleep_i,
  input  wire logic       idle_i,
  input  wire logic       undervolt_reset_en_i,
  output var  logic [2:0] trip_level_select_o,
  output var  logic       detector_on_o,
  output var  logic       bandgap_on_o,
  // Processor side.
  output var  logic       cpu_irq_o,
  output var  logic       idle_wake_o,
  output var  logic       event_irq_o
);
  logic [7:0] undervolt_control;
  logic [7:0] irq_control_0;
  logic [7:0] irq_control_1;
  logic [2:0] event_status;
  logic [2:0] event_mask;
  logic       cmp_meta;
  logic       cmp_sync;
  logic       low_supply_flag;
  logic       low_prev;
  logic       delay_done;
  logic       delay_prev;
  logic       ack_pending;
  logic       flag_rise;
  logic [2:0] event_hit;
  logic       wr_lo;
  logic [31:0] next_readdata;
  logic       next_err;

  // One wait cycle per access keeps read data registered and gives a simple fixed answer time.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_pending       <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && !ack_pending) begin
      ack_pending       <= 1'b1;
      avs_waitrequest_o <= 1'b0;
    end else begin
      ack_pending       <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Writes take effect at the edge where waitrequest is sampled low.
  assign wr_lo = avs_write_i && ack_pending && avs_byteenable_i[0];

  // The first stage feeds only the second one.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= comparator_i;
      cmp_sync <= cmp_meta;
    end
  end

  // The comparator is only meaningful while the detector is really on.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_supply_flag <= 1'b0;
    end else begin
      low_supply_flag <= cmp_sync && detector_on_o;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      detector_on_o       <= 1'b0;
      bandgap_on_o        <= 1'b0;
      trip_level_select_o <= 3'h0;
    end else begin
      detector_on_o       <= undervolt_control[DETECTOR_EN_BIT] && !sleep_i;
      bandgap_on_o        <= undervolt_control[DETECTOR_EN_BIT] || undervolt_reset_en_i
                             || undervolt_control[BANDGAP_BUF_BIT];
      trip_level_select_o <= undervolt_control[TRIP_SEL_LSB +: 3];
    end
  end

  suvm_delay #(
    .DELAY_CYCLES (IRQ_DELAY_CYCLES)
  ) u_delay (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .low_i      (low_supply_flag),
    .expired_o  (delay_done)
  );

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_prev <= 1'b0;
      low_prev   <= 1'b0;
    end else begin
      delay_prev <= delay_done;
      low_prev   <= low_supply_flag;
    end
  end

  assign flag_rise = delay_done && !delay_prev;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      undervolt_control <= UNDERVOLT_CTRL_RST;
    end else if (wr_lo && avs_address_i == ADDR_UNDERVOLT_CTRL) begin
      undervolt_control <= avs_writedata_i[7:0] & CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_control_0 <= IRQ_CONTROL_0_RST;
    end else if (wr_lo && avs_address_i == ADDR_IRQ_CONTROL_0) begin
      irq_control_0 <= avs_writedata_i[7:0] & IRQC0_WRITE_MASK;
    end
  end

  // The delayed event wins over a software write in the same cycle.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_control_1 <= IRQ_CONTROL_1_RST;
    end else begin
      if (wr_lo && avs_address_i == ADDR_IRQ_CONTROL_1) begin
        irq_control_1 <= avs_writedata_i[7:0];
      end
      if (flag_rise) begin
        irq_control_1[UV_IRQ_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Wake only on a new request; a flag preset by software produces no edge.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_wake_o <= 1'b0;
    end else begin
      idle_wake_o <= flag_rise && !irq_control_1[UV_IRQ_FLAG_BIT] && idle_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_irq_o <= 1'b0;
    end else begin
      cpu_irq_o <= irq_control_1[UV_IRQ_FLAG_BIT] && irq_control_1[UV_IRQ_EN_BIT]
                   && irq_control_0[GLOBAL_IRQ_EN_BIT];
    end
  end

  assign event_hit[EVT_LOW_RISE_BIT] = low_supply_flag && !low_prev;
  assign event_hit[EVT_IRQ_SET_BIT]  = flag_rise;
  assign event_hit[EVT_WAKE_BIT]     = idle_wake_o;

  // Write-one-to-clear, with a fresh event beating the clear.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_status <= 3'h0;
      event_mask   <= EVENT_MASK_RST;
    end else begin
      if (wr_lo && avs_address_i == ADDR_EVENT_MASK) begin
        event_mask <= avs_writedata_i[2:0];
      end
      if (wr_lo && avs_address_i == ADDR_EVENT_STATUS) begin
        event_status <= (event_status & ~avs_writedata_i[2:0]) | event_hit;
      end else begin
        event_status <= event_status | event_hit;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_irq_o <= 1'b0;
    end else begin
      event_irq_o <= |(event_status & event_mask);
    end
  end

  always_comb begin
    next_readdata = 32'h0;
    next_err      = 1'b0;
    case (avs_address_i)
      ADDR_UNDERVOLT_CTRL: begin
        next_readdata[7:0] = undervolt_control;
        next_readdata[LOW_SUPPLY_BIT] = low_supply_flag;
      end
      ADDR_IRQ_CONTROL_0:  next_readdata[7:0] = irq_control_0;
      ADDR_IRQ_CONTROL_1:  next_readdata[7:0] = irq_control_1;
      ADDR_EVENT_STATUS:   next_readdata[2:0] = event_status;
      ADDR_EVENT_MASK:     next_readdata[2:0] = event_mask;
      ADDR_MONITOR_STATUS: next_readdata[2:0] = {bandgap_on_o, detector_on_o, delay_done};
      default:             next_err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
      avs_response_o <= 2'h0;
    end else if ((avs_read_i || avs_write_i) && !ack_pending) begin
      avs_readdata_o <= avs_read_i ? next_readdata : 32'h0;
      avs_response_o <= next_err ? 2'h3 : 2'h0;
    end
  end
endmodule : suvm_top
`default_nettype wire

// *** verif/suvm_top_monitor.sv ***
// Checker of bus timing, read-back and power-control outputs of the undervoltage monitor.
`timescale 1ns/100ps
`default_nettype none
module suvm_top_monitor
  import suvm_pkg::*;
#(
  parameter int unsigned IRQ_DELAY_CYCLES = 8
) (
  // Watched ports.
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  avs_response_o,
  input wire logic        comparator_i,
  input wire logic        sleep_i,
  input wire logic        undervolt_reset_en_i,
  input wire logic [2:0]  trip_level_select_o,
  input wire logic        detector_on_o,
  input wire logic        bandgap_on_o,
  input wire logic        idle_wake_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire rd_done = avs_read_i && !avs_waitrequest_o;
  wire ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_UNDERVOLT_CTRL;
  int unsigned low_run;
  // Counts how long the comparator has stayed low-supply, since a wake must follow the full delay.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_run <= 0;
    end else begin
      low_run <= comparator_i ? low_run + 1 : 0;
    end
  end
  sequence s_answer; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  sequence s_no_ctrl_wr; !ctrl_wr ##1 !ctrl_wr; endsequence
  property p_bus_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_answer; endproperty
  property p_unmapped; rd_done && avs_address_i > ADDR_MONITOR_STATUS |-> avs_response_o == 2'b11
    && avs_readdata_o == 32'h0; endproperty
  property p_mapped; rd_done && avs_address_i <= ADDR_MONITOR_STATUS |-> avs_response_o == 2'b00
    && avs_readdata_o[31:8] == 24'h0; endproperty
  property p_ctrl_unused; rd_done && avs_address_i == ADDR_UNDERVOLT_CTRL |-> avs_readdata_o[7:6] == 2'b00; endproperty
  property p_trip_hold; s_no_ctrl_wr |=> $stable(trip_level_select_o); endproperty
  property p_sleep_off; sleep_i |=> !detector_on_o; endproperty
  property p_bandgap; undervolt_reset_en_i |=> bandgap_on_o; endproperty
  property p_wake_pulse; idle_wake_o |=> !idle_wake_o; endproperty
  property p_wake_late; idle_wake_o |-> low_run > IRQ_DELAY_CYCLES; endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("waitrequest not one cycle low");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_mapped: assert property (p_mapped) else $error("mapped read bad response");
  a_ctrl_unused: assert property (p_ctrl_unused) else $error("control bits 7:6 not zero");
  a_trip_hold: assert property (p_trip_hold) else $error("trip level moved without write");
  a_sleep_off: assert property (p_sleep_off) else $error("detector on in sleep");
  a_bandgap: assert property (p_bandgap) else $error("bandgap off with reset enabled");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  a_wake_late: assert property (p_wake_late) else $error("wake before the qualification delay");
endmodule : suvm_top_monitor
bind suvm_top suvm_top_monitor #(.IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES)) u_suvm_top_monitor (.core_clk_i, .rst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .comparator_i, .sleep_i,
  .undervolt_reset_en_i, .trip_level_select_o, .detector_on_o, .bandgap_on_o, .idle_wake_o);
`default_nettype wire

// *** verif/suvm_top_bench.sv ***
// Self-checking bench for the undervoltage monitor registers, interrupts and power control.
`timescale 1ns/100ps
`default_nettype none
module suvm_top_bench;
  import suvm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, comp = 1'b0, slp = 1'b0, idl = 1'b0, rsten = 1'b0;
  logic [3:0]  ad = 4'h0;
  logic [31:0] wd = 32'h0, rdata, rv;
  logic [1:0]  resp, rs;
  logic        wtr, cirq, wake, eirq, det, bg;
  logic [2:0]  trip;
  int          n_fail = 0, num_checks = 0, seen;
  // The short delay keeps the interrupt qualification visible in a short run.
  suvm_top #(.IRQ_DELAY_CYCLES(8)) u_suvm_top (.core_clk_i(clk), .rst_i(rst), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wtr), .avs_response_o(resp), .comparator_i(comp),
    .sleep_i(slp), .idle_i(idl), .undervolt_reset_en_i(rsten), .trip_level_select_o(trip),
    .detector_on_o(det), .bandgap_on_o(bg), .cpu_irq_o(cirq), .idle_wake_o(wake), .event_irq_o(eirq));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One access; an edge passes first so a released strobe is never raised in the same step.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    while (wtr !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    rv = rdata;
    rs = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) n_fail++;
  endtask : acc
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rv);
  endtask : rdchk
  task automatic count_wake;
    seen = 0;
    repeat (40) begin
      @(posedge clk);
      if (wake === 1'b1) seen++;
    end
  endtask : count_wake
  initial begin
    cyc(2);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rdchk("reset", 4'(i), 8'h00);
    acc(1'b1, ADDR_UNDERVOLT_CTRL, 8'hff);
    rdchk("ctrl", ADDR_UNDERVOLT_CTRL, 8'h1f);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, ADDR_UNDERVOLT_CTRL, 8'h10 | 8'(i));
      cyc(3);
      chk("trip", 32'(i), {29'h0, trip});
    end
    chk("det", 32'h1, {31'h0, det});
    slp <= 1'b1;
    cyc(3);
    chk("sleep", 32'h0, {31'h0, det});
    slp <= 1'b0;
    acc(1'b1, ADDR_UNDERVOLT_CTRL, 8'h00);
    cyc(3);
    chk("bg off", 32'h0, {30'h0, det, bg});
    rsten <= 1'b1;
    cyc(3);
    chk("bg rst", 32'h1, {31'h0, bg});
    rsten <= 1'b0;
    acc(1'b1, ADDR_UNDERVOLT_CTRL, 8'h08);
    cyc(3);
    chk("bg buf", 32'h1, {31'h0, bg});
    rdchk("mon", ADDR_MONITOR_STATUS, 8'h04);
    acc(1'b1, ADDR_UNDERVOLT_CTRL, 8'h10);
    comp <= 1'b1;
    rdchk("early", ADDR_IRQ_CONTROL_1, 8'h00);
    cyc(20);
    rdchk("low", ADDR_UNDERVOLT_CTRL, 8'h30);
    rdchk("irqf", ADDR_IRQ_CONTROL_1, 8'h20);
    acc(1'b1, ADDR_IRQ_CONTROL_1, 8'h22);
    cyc(3);
    chk("no gie", 32'h0, {31'h0, cirq});
    acc(1'b1, ADDR_IRQ_CONTROL_0, 8'hff);
    rdchk("irqc0", ADDR_IRQ_CONTROL_0, 8'h7f);
    chk("irq", 32'h1, {31'h0, cirq});
    acc(1'b1, ADDR_IRQ_CONTROL_1, 8'h20);
    cyc(3);
    chk("no le", 32'h0, {31'h0, cirq});
    comp <= 1'b0;
    cyc(5);
    rdchk("high", ADDR_UNDERVOLT_CTRL, 8'h10);
    acc(1'b1, ADDR_IRQ_CONTROL_1, 8'h00);
    // Short dips below the trip level must not be taken for a settled low supply.
    repeat (3) begin
      comp <= 1'b1;
      cyc(4);
      comp <= 1'b0;
      cyc(4);
    end
    rdchk("toggle", ADDR_IRQ_CONTROL_1, 8'h00);
    idl <= 1'b1;
    comp <= 1'b1;
    count_wake;
    chk("wake", 32'h1, 32'(seen));
    comp <= 1'b0;
    cyc(5);
    acc(1'b1, ADDR_IRQ_CONTROL_1, 8'h20);
    comp <= 1'b1;
    count_wake;
    chk("no wake", 32'h0, 32'(seen));
    rdchk("events", ADDR_EVENT_STATUS, 8'h07);
    chk("masked", 32'h0, {31'h0, eirq});
    acc(1'b1, ADDR_EVENT_MASK, 8'h04);
    cyc(3);
    chk("evt irq", 32'h1, {31'h0, eirq});
    acc(1'b1, ADDR_EVENT_STATUS, 8'h04);
    rdchk("cleared", ADDR_EVENT_STATUS, 8'h03);
    chk("evt off", 32'h0, {31'h0, eirq});
    acc(1'b1, 4'hf, 8'hff);
    rdchk("unmapped", 4'hf, 8'h00);
    chk("resp", 32'h3, {30'h0, rs});
    finish_test;
  end
  initial begin
    cyc(20000);
    n_fail++;
    finish_test;
  end
endmodule : suvm_top_bench
`default_nettype wire
